// [cbs_pkg.sv]
// How it works
// - Low-power 16-bit indexed jump: four cycles, low offset byte read twice.
// - Low-power 16-bit indexed reads: five cycles, last reads index plus offset.
// - Low-power 16-bit indexed stores: six cycles, write at index plus offset.
// - Low-power 16-bit indexed call: seven cycles, pushes return low then high.
// - Power-on runs 1922 cycles, vector fetched in cycles 1920 and 1921.
// - Interrupt request seen low in an instruction's last cycle starts ten-cycle entry.
// - Interrupt entry: two reads at next opcode, then five pushes downward.
// - Entry cycles eight and nine read the external or timer vector bytes.
// - Parts with an 11-bit counter use page 07 instead of 1F for reset, interrupt and timer vectors.
// - Inherent register read-modify-write: four cycles, last two at opcode plus two.
// - Flag, stack reset, no-op and transfer inherents: two cycles.
// - Subroutine return: six cycles reading stack pointer plus zero to plus three.
// - Software interrupt: eleven cycles, five pushes, idle read, vector at $7FC.
// - Interrupt return: nine cycles reading stack pointer up to plus six.
// - Immediate operations: two cycles, operand read at opcode plus one.
// - Bit set or clear: seven cycles, unused read at $07F, write last.
// - Bit test and branch: ten cycles, unused read, operand reads, two opcode reads.
// - Relative branches: four cycles, offset at opcode plus one, then plus two.
// - External-bus part ignores bus data during return stack reads.
package cbs_pkg;

    // ==========================================================
    // Address map and vectors
    localparam int ADDR_W = 13;
    localparam logic [7:0] PAGE_PC13 = 8'h1F;
    localparam logic [7:0] PAGE_PC11 = 8'h07;
    localparam logic [7:0] VEC_RST_HI = 8'hFE;
    localparam logic [7:0] VEC_RST_LO = 8'hFF;
    localparam logic [7:0] VEC_IRQ_HI = 8'hFA;
    localparam logic [7:0] VEC_IRQ_LO = 8'hFB;
    localparam logic [7:0] VEC_TMR_HI = 8'hF9;
    localparam logic [7:0] VEC_TMR_LO = 8'hF8;
    localparam logic [15:0] VEC_SWI = 16'h07FC;
    localparam logic [15:0] UNUSED_ADDR = 16'h007F;

    // ==========================================================
    // Sequence lengths in machine cycles
    localparam int STEP_W = 11;
    localparam logic [10:0] LEN_JMP16 = 11'h4;
    localparam logic [10:0] LEN_RD16 = 11'h5;
    localparam logic [10:0] LEN_ST16 = 11'h6;
    localparam logic [10:0] LEN_JSR16 = 11'h7;
    localparam logic [10:0] LEN_RESET = 11'h5;
    localparam int LEN_POR = 1922;
    localparam logic [10:0] LEN_IRQ = 11'hA;
    localparam logic [10:0] LEN_INH_RMW = 11'h4;
    localparam logic [10:0] LEN_INH2 = 11'h2;
    localparam logic [10:0] LEN_RTS = 11'h6;
    localparam logic [10:0] LEN_SWI = 11'hB;
    localparam logic [10:0] LEN_RTI = 11'h9;
    localparam logic [10:0] LEN_IMM = 11'h2;
    localparam logic [10:0] LEN_BIT = 11'h7;
    localparam logic [10:0] LEN_BRBIT = 11'hA;
    localparam logic [10:0] LEN_REL = 11'h4;

    // ==========================================================
    // Enumerations
    typedef enum logic [2:0] {
        S_HOLD = 3'b001,
        S_RUN = 3'b010,
        S_WAIT = 3'b100
    } cbs_state_t;

    typedef enum logic [3:0] {
        CL_JMP16, CL_RD16, CL_ST16, CL_JSR16, CL_INH_RMW, CL_INH2, CL_RTS, CL_SWI,
        CL_RTI, CL_IMM, CL_BIT, CL_BRBIT, CL_REL, CL_RESET, CL_POR, CL_IRQ
    } cbs_cls_t;

    typedef enum logic [3:0] {
        A_OP, A_OP1, A_OP2, A_OP3, A_IX, A_OPND, A_UNUSED, A_SP, A_VHI, A_VLO, A_VEC
    } cbs_asrc_t;

    typedef enum logic [2:0] {
        W_NONE, W_RLO, W_RHI, W_IX, W_AC, W_CC, W_NEW
    } cbs_wsel_t;

    typedef enum logic [1:0] {
        K_NONE, K_HI, K_LO, K_OPND
    } cbs_cap_t;

    typedef enum logic [1:0] {
        VK_RST, VK_IRQ, VK_TMR, VK_SWI
    } cbs_vk_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        cbs_asrc_t src;
        cbs_wsel_t wsel;
        cbs_cap_t cap;
        logic signed [3:0] delta;
    } cbs_step_t;

    typedef struct packed {
        cbs_cls_t cls;
        logic [ADDR_W-1:0] opc;
        logic [ADDR_W-1:0] sp;
        logic [7:0] idx;
        logic [7:0] acc;
        logic [7:0] ccr;
        logic [7:0] wdata;
    } cbs_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rw;
        logic [7:0] wdata;
        logic valid;
        logic ignore;
    } cbs_bus_t;

endpackage

// [cbs_vec_addr.sv]
`timescale 1ns/1ps
module cbs_vec_addr #(
    parameter bit PC11 = 1'b0
) (
    input wire cbs_pkg::cbs_vk_t kind,
    input wire logic lo,
    output logic [cbs_pkg::ADDR_W-1:0] addr
);

    localparam int AW = cbs_pkg::ADDR_W;

    logic [7:0] page;
    logic [7:0] off;

    always_comb
    begin
        page = PC11 ? cbs_pkg::PAGE_PC11 : cbs_pkg::PAGE_PC13;
        case (kind)
            cbs_pkg::VK_IRQ: off = lo ? cbs_pkg::VEC_IRQ_LO : cbs_pkg::VEC_IRQ_HI;
            cbs_pkg::VK_TMR: off = lo ? cbs_pkg::VEC_TMR_LO : cbs_pkg::VEC_TMR_HI;
            default: off = lo ? cbs_pkg::VEC_RST_LO : cbs_pkg::VEC_RST_HI;
        endcase
        if (kind == cbs_pkg::VK_SWI)
        begin
            addr = AW'(cbs_pkg::VEC_SWI + {15'h0, lo});
        end
        else
        begin
            addr = AW'({page, off});
        end
    end

endmodule

// [cbs_sequencer.sv]
`timescale 1ns/1ps
module cbs_sequencer #(
    parameter bit PC11 = 1'b0,
    parameter bit EXT_BUS = 1'b0,
    parameter int POR_LEN = cbs_pkg::LEN_POR
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cpu_reset_n,
    input wire logic irq_n,
    input wire logic timer_req,
    input wire logic irq_mask,
    input wire cbs_pkg::cbs_cmd_t cmd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [cbs_pkg::ADDR_W-1:0] next_pc,
    input wire logic [7:0] rdata,
    output cbs_pkg::cbs_bus_t bus,
    output logic insn_done,
    output logic [15:0] vector,
    output logic busy
);

    localparam int AW = cbs_pkg::ADDR_W;
    localparam logic [10:0] POR_STEPS = 11'(POR_LEN);

    // ==========================================================
    // Per-cycle plan tables
    function automatic cbs_pkg::cbs_step_t mk(cbs_pkg::cbs_asrc_t s, cbs_pkg::cbs_wsel_t w,
                                              cbs_pkg::cbs_cap_t k, logic signed [3:0] d);
        mk.src = s;
        mk.wsel = w;
        mk.cap = k;
        mk.delta = d;
    endfunction

    function automatic logic [10:0] len_of(cbs_pkg::cbs_cls_t c);
        case (c)
            cbs_pkg::CL_JMP16: len_of = cbs_pkg::LEN_JMP16;
            cbs_pkg::CL_RD16: len_of = cbs_pkg::LEN_RD16;
            cbs_pkg::CL_ST16: len_of = cbs_pkg::LEN_ST16;
            cbs_pkg::CL_JSR16: len_of = cbs_pkg::LEN_JSR16;
            cbs_pkg::CL_INH_RMW: len_of = cbs_pkg::LEN_INH_RMW;
            cbs_pkg::CL_INH2: len_of = cbs_pkg::LEN_INH2;
            cbs_pkg::CL_RTS: len_of = cbs_pkg::LEN_RTS;
            cbs_pkg::CL_SWI: len_of = cbs_pkg::LEN_SWI;
            cbs_pkg::CL_RTI: len_of = cbs_pkg::LEN_RTI;
            cbs_pkg::CL_IMM: len_of = cbs_pkg::LEN_IMM;
            cbs_pkg::CL_BIT: len_of = cbs_pkg::LEN_BIT;
            cbs_pkg::CL_BRBIT: len_of = cbs_pkg::LEN_BRBIT;
            cbs_pkg::CL_REL: len_of = cbs_pkg::LEN_REL;
            cbs_pkg::CL_POR: len_of = POR_STEPS;
            cbs_pkg::CL_IRQ: len_of = cbs_pkg::LEN_IRQ;
            default: len_of = cbs_pkg::LEN_RESET;
        endcase
    endfunction

    // Push order shared by hardware and software interrupt entry.
    function automatic cbs_pkg::cbs_wsel_t push_w(logic [10:0] k);
        case (k)
            11'h0: push_w = cbs_pkg::W_RLO;
            11'h1: push_w = cbs_pkg::W_RHI;
            11'h2: push_w = cbs_pkg::W_IX;
            11'h3: push_w = cbs_pkg::W_AC;
            default: push_w = cbs_pkg::W_CC;
        endcase
    endfunction

    function automatic cbs_pkg::cbs_step_t plan(cbs_pkg::cbs_cls_t c, logic [10:0] s);
        logic [10:0] l;
        l = len_of(c);
        plan = mk(cbs_pkg::A_OP, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
        case (c)
            cbs_pkg::CL_JMP16, cbs_pkg::CL_RD16, cbs_pkg::CL_ST16, cbs_pkg::CL_JSR16:
            begin
                if (s == 11'h2)
                    plan = mk(cbs_pkg::A_OP1, cbs_pkg::W_NONE, cbs_pkg::K_HI, 4'sh0);
                else if (s == 11'h3)
                    plan = mk(cbs_pkg::A_OP2, cbs_pkg::W_NONE, cbs_pkg::K_LO, 4'sh0);
                else if (s == 11'h4 || (s == 11'h5 && c == cbs_pkg::CL_ST16))
                    plan = mk(cbs_pkg::A_OP2, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
                else if (s == 11'h5)
                    plan = mk(cbs_pkg::A_IX, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
                else if (s == 11'h6 && c == cbs_pkg::CL_ST16)
                    plan = mk(cbs_pkg::A_IX, cbs_pkg::W_NEW, cbs_pkg::K_NONE, 4'sh0);
                else if (s == 11'h6)
                    plan = mk(cbs_pkg::A_SP, cbs_pkg::W_RLO, cbs_pkg::K_NONE, 4'sh0);
                else if (s == 11'h7)
                    plan = mk(cbs_pkg::A_SP, cbs_pkg::W_RHI, cbs_pkg::K_NONE, -4'sh1);
            end
            cbs_pkg::CL_INH_RMW, cbs_pkg::CL_REL:
            begin
                if (s == 11'h2)
                    plan = mk(cbs_pkg::A_OP1, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
                else if (s >= 11'h3)
                    plan = mk(cbs_pkg::A_OP2, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
            end
            cbs_pkg::CL_INH2, cbs_pkg::CL_IMM:
            begin
                if (s == 11'h2)
                    plan = mk(cbs_pkg::A_OP1, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
            end
            cbs_pkg::CL_RTS, cbs_pkg::CL_RTI:
            begin
                if (s == 11'h2)
                    plan = mk(cbs_pkg::A_OP1, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
                else if (s >= 11'h3)
                    plan = mk(cbs_pkg::A_SP, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'(s - 11'h3));
            end
            cbs_pkg::CL_SWI, cbs_pkg::CL_IRQ:
            begin
                if (s == 11'h2 && c == cbs_pkg::CL_SWI)
                    plan = mk(cbs_pkg::A_OP1, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
                else if (s >= 11'h3 && s <= 11'h7)
                    plan = mk(cbs_pkg::A_SP, push_w(s - 11'h3), cbs_pkg::K_NONE, 4'(11'h3 - s));
                else if (s == 11'h8 && c == cbs_pkg::CL_SWI)
                    plan = mk(cbs_pkg::A_SP, cbs_pkg::W_NONE, cbs_pkg::K_NONE, -4'sh5);
                else if (s == l - 11'h2)
                    plan = mk(cbs_pkg::A_VHI, cbs_pkg::W_NONE, cbs_pkg::K_HI, 4'sh0);
                else if (s == l - 11'h1)
                    plan = mk(cbs_pkg::A_VLO, cbs_pkg::W_NONE, cbs_pkg::K_LO, 4'sh0);
                else if (s == l)
                    plan = mk(cbs_pkg::A_VEC, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
            end
            cbs_pkg::CL_BIT, cbs_pkg::CL_BRBIT:
            begin
                if (s == 11'h2)
                    plan = mk(cbs_pkg::A_OP1, cbs_pkg::W_NONE, cbs_pkg::K_OPND, 4'sh0);
                else if (s == 11'h3)
                    plan = mk(cbs_pkg::A_UNUSED, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
                else if (c == cbs_pkg::CL_BIT && s == l)
                    plan = mk(cbs_pkg::A_OPND, cbs_pkg::W_NEW, cbs_pkg::K_NONE, 4'sh0);
                else if (c == cbs_pkg::CL_BRBIT && s == l - 11'h1)
                    plan = mk(cbs_pkg::A_OP2, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
                else if (c == cbs_pkg::CL_BRBIT && s == l)
                    plan = mk(cbs_pkg::A_OP3, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
                else if (s >= 11'h4)
                    plan = mk(cbs_pkg::A_OPND, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
            end
            default:
            begin
                // Reset and power-on share one shape; only the length differs.
                if (s + 11'h2 <= l)
                    plan = mk(cbs_pkg::A_VHI, cbs_pkg::W_NONE,
                              (s == l - 11'h2) ? cbs_pkg::K_HI : cbs_pkg::K_NONE, 4'sh0);
                else if (s == l - 11'h1)
                    plan = mk(cbs_pkg::A_VLO, cbs_pkg::W_NONE, cbs_pkg::K_LO, 4'sh0);
                else
                    plan = mk(cbs_pkg::A_VEC, cbs_pkg::W_NONE, cbs_pkg::K_NONE, 4'sh0);
            end
        endcase
    endfunction

    // ==========================================================
    // State
    cbs_pkg::cbs_state_t state_r, state_nxt;
    cbs_pkg::cbs_cls_t cls_r, cls_nxt;
    logic [10:0] step_r, step_nxt;
    logic tmr_r, tmr_nxt;
    cbs_pkg::cbs_cmd_t cmd_r, cmd_nxt;
    logic [15:0] cap_r, cap_nxt;
    logic [7:0] opnd_r, opnd_nxt;
    cbs_pkg::cbs_bus_t bus_r, bus_nxt;
    logic done_r;
    cbs_pkg::cbs_step_t cur, pn;
    logic last, bound, take, accept, is_insn;
    cbs_pkg::cbs_vk_t vk_nxt;
    logic [AW-1:0] vaddr, ret;
    // A constant, so that the asynchronous reset branch loads no logic output.
    localparam logic [AW-1:0] RST_HI_ADDR =
        AW'({PC11 ? cbs_pkg::PAGE_PC11 : cbs_pkg::PAGE_PC13, cbs_pkg::VEC_RST_HI});
    assign cur = plan(cls_r, step_r);
    assign is_insn = !(cls_r inside {cbs_pkg::CL_RESET, cbs_pkg::CL_POR, cbs_pkg::CL_IRQ});
    assign last = (state_r == cbs_pkg::S_RUN) && (step_r == len_of(cls_r));
    assign bound = (state_r == cbs_pkg::S_WAIT) || last;
    // The request is sampled only at an instruction boundary; its level is ignored afterwards.
    assign take = bound && cpu_reset_n && !irq_mask && (!irq_n || timer_req)
                  && !(last && !is_insn);
    assign cmd_ready = bound && cpu_reset_n && !take;
    assign accept = cmd_ready && cmd_valid;

    // ==========================================================
    // Next-step selection
    always_comb
    begin
        state_nxt = state_r;
        cls_nxt = cls_r;
        step_nxt = step_r;
        tmr_nxt = tmr_r;
        if (!cpu_reset_n)
        begin
            state_nxt = cbs_pkg::S_HOLD;
            cls_nxt = cbs_pkg::CL_RESET;
            step_nxt = 11'h0;
        end
        else if (state_r == cbs_pkg::S_HOLD)
        begin
            state_nxt = cbs_pkg::S_RUN;
            step_nxt = 11'h1;
        end
        else if (take)
        begin
            state_nxt = cbs_pkg::S_RUN;
            cls_nxt = cbs_pkg::CL_IRQ;
            step_nxt = 11'h1;
            tmr_nxt = irq_n;
        end
        else if (accept)
        begin
            state_nxt = cbs_pkg::S_RUN;
            cls_nxt = cmd.cls;
            step_nxt = 11'h1;
        end
        else if (bound)
        begin
            state_nxt = cbs_pkg::S_WAIT;
        end
        else
        begin
            step_nxt = step_r + 11'h1;
        end
    end

    always_comb
    begin
        cmd_nxt = cmd_r;
        if (take || accept)
        begin
            cmd_nxt = cmd;
        end
        if (take)
        begin
            cmd_nxt.opc = next_pc;
        end
    end

    // Same-cycle bypass: a vector low byte is needed for the very next address.
    always_comb
    begin
        cap_nxt = cap_r;
        opnd_nxt = opnd_r;
        if (state_r == cbs_pkg::S_RUN)
        begin
            case (cur.cap)
                cbs_pkg::K_HI: cap_nxt[15:8] = rdata;
                cbs_pkg::K_LO: cap_nxt[7:0] = rdata;
                cbs_pkg::K_OPND: opnd_nxt = rdata;
                default: ;
            endcase
        end
    end

    assign pn = plan(cls_nxt, step_nxt);

    always_comb
    begin
        case (cls_nxt)
            cbs_pkg::CL_IRQ: vk_nxt = tmr_nxt ? cbs_pkg::VK_TMR : cbs_pkg::VK_IRQ;
            cbs_pkg::CL_SWI: vk_nxt = cbs_pkg::VK_SWI;
            default: vk_nxt = cbs_pkg::VK_RST;
        endcase
    end

    cbs_vec_addr #(.PC11(PC11)) u_vec (
        .kind(vk_nxt),
        .lo(pn.src == cbs_pkg::A_VLO),
        .addr(vaddr)
    );

    always_comb
    begin
        case (cls_nxt)
            cbs_pkg::CL_JSR16: ret = cmd_nxt.opc + AW'(3);
            cbs_pkg::CL_SWI: ret = cmd_nxt.opc + AW'(1);
            default: ret = cmd_nxt.opc;
        endcase
    end

    // ==========================================================
    // Bus drive for the coming cycle
    always_comb
    begin
        bus_nxt.valid = (state_nxt != cbs_pkg::S_WAIT);
        bus_nxt.rw = (pn.wsel == cbs_pkg::W_NONE) || (state_nxt != cbs_pkg::S_RUN);
        bus_nxt.ignore = EXT_BUS && (pn.src == cbs_pkg::A_SP) && (state_nxt == cbs_pkg::S_RUN)
                         && (cls_nxt inside {cbs_pkg::CL_RTS, cbs_pkg::CL_RTI});
        case (pn.src)
            cbs_pkg::A_OP1: bus_nxt.addr = cmd_nxt.opc + AW'(1);
            cbs_pkg::A_OP2: bus_nxt.addr = cmd_nxt.opc + AW'(2);
            cbs_pkg::A_OP3: bus_nxt.addr = cmd_nxt.opc + AW'(3);
            cbs_pkg::A_IX: bus_nxt.addr = AW'({8'h00, cmd_nxt.idx} + cap_nxt);
            cbs_pkg::A_OPND: bus_nxt.addr = AW'(opnd_nxt);
            cbs_pkg::A_UNUSED: bus_nxt.addr = AW'(cbs_pkg::UNUSED_ADDR);
            cbs_pkg::A_SP: bus_nxt.addr = cmd_nxt.sp + AW'(pn.delta);
            cbs_pkg::A_VHI, cbs_pkg::A_VLO: bus_nxt.addr = vaddr;
            cbs_pkg::A_VEC: bus_nxt.addr = AW'(cap_nxt);
            default: bus_nxt.addr = cmd_nxt.opc;
        endcase
        case (pn.wsel)
            cbs_pkg::W_RLO: bus_nxt.wdata = ret[7:0];
            cbs_pkg::W_RHI: bus_nxt.wdata = 8'(ret >> 8);
            cbs_pkg::W_IX: bus_nxt.wdata = cmd_nxt.idx;
            cbs_pkg::W_AC: bus_nxt.wdata = cmd_nxt.acc;
            cbs_pkg::W_CC: bus_nxt.wdata = cmd_nxt.ccr;
            cbs_pkg::W_NEW: bus_nxt.wdata = cmd_nxt.wdata;
            default: bus_nxt.wdata = 8'h00;
        endcase
        if (state_nxt == cbs_pkg::S_HOLD)
        begin
            bus_nxt.addr = RST_HI_ADDR;
        end
        if (state_nxt == cbs_pkg::S_WAIT)
        begin
            bus_nxt.addr = bus_r.addr;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= cbs_pkg::S_RUN;
            cls_r <= cbs_pkg::CL_POR;
            step_r <= 11'h1;
            tmr_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cls_r <= cls_nxt;
            step_r <= step_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cmd_r <= '0;
            cap_r <= 16'h0000;
            opnd_r <= 8'h00;
        end
        else
        begin
            cmd_r <= cmd_nxt;
            cap_r <= cap_nxt;
            opnd_r <= opnd_nxt;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bus_r.addr <= RST_HI_ADDR;
            bus_r.rw <= 1'b1;
            bus_r.wdata <= 8'h00;
            bus_r.valid <= 1'b1;
            bus_r.ignore <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            bus_r <= bus_nxt;
            done_r <= last && cpu_reset_n;
        end
    end

    assign bus = bus_r;
    assign insn_done = done_r;
    assign vector = cap_r;
    assign busy = (state_r != cbs_pkg::S_WAIT);

endmodule

// [cbs_mem.sv]
`timescale 1ns/1ps
// ==========================================================
// Program and data memory
// Unselected or write cycles show inverted data, so a stale byte never passes for a read.
module cbs_mem (
    input wire cbs_pkg::cbs_bus_t bus,
    output logic [7:0] rdata
);
    logic [7:0] pat;
    assign pat = (bus.addr[7:0] ^ 8'h3C) & 8'h0F;
    assign rdata = (bus.valid && bus.rw) ? pat : ~pat;
endmodule

// [cbs_sequencer_chk.sv]
`timescale 1ns/1ps
// ==========================================================
// Bus cycle checker
module cbs_sequencer_chk #(
    parameter bit PC11 = 1'b0,
    parameter bit EXT_BUS = 1'b0,
    parameter int POR_LEN = 1922
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cpu_reset_n,
    input wire cbs_pkg::cbs_cmd_t cmd,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire cbs_pkg::cbs_bus_t bus,
    input wire logic insn_done
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    localparam logic [12:0] PG = PC11 ? 13'h0700 : 13'h1F00;
    wire acc = cmd_valid && cmd_ready;
    chk_imm_two_cycles: assert property (acc && cmd.cls == cbs_pkg::CL_IMM |=> bus.addr == $past(cmd.opc)
        ##1 bus.addr == $past(cmd.opc, 2) + 13'h1 ##1 insn_done) else $error("immediate sequence wrong");
    chk_jmp_low_twice: assert property (acc && cmd.cls == cbs_pkg::CL_JMP16 |=> ##2
        bus.addr == $past(cmd.opc, 3) + 13'h2 ##1 bus.addr == $past(cmd.opc, 4) + 13'h2 ##1 insn_done)
        else $error("indexed jump sequence wrong");
    chk_store_last_write: assert property (acc && cmd.cls == cbs_pkg::CL_ST16 |=> bus.rw [*5]
        ##1 (!bus.rw && bus.wdata == $past(cmd.wdata, 6)) ##1 insn_done) else $error("indexed store wrong");
    chk_swi_vector: assert property (acc && cmd.cls == cbs_pkg::CL_SWI |=> ##8
        bus.addr == 13'h07FC ##1 bus.addr == 13'h07FD) else $error("software interrupt vector wrong");
    chk_rts_stack_ignore: assert property (acc && cmd.cls == cbs_pkg::CL_RTS |=> ##2
        (bus.rw && bus.ignore == EXT_BUS) [*4] ##1 insn_done) else $error("subroutine return wrong");
    chk_irq_vector_pair: assert property (bus.valid && bus.rw && bus.addr == 13'h1FFA |=>
        bus.addr == 13'h1FFB ##2 insn_done) else $error("interrupt vector pair wrong");
    chk_reset_hold_addr: assert property (!cpu_reset_n |=> bus.addr == PG + 13'h0FE && bus.rw)
        else $error("reset hold address wrong");
    chk_reset_release: assert property ($rose(cpu_reset_n) |-> ##[3:5] bus.addr == PG + 13'h0FF ##1 cmd_ready)
        else $error("reset release sequence wrong");
endmodule
bind cbs_sequencer cbs_sequencer_chk #(.PC11(PC11), .EXT_BUS(EXT_BUS), .POR_LEN(POR_LEN)) i_cbs_sequencer_chk (
    .mclk(mclk), .rst(rst), .cpu_reset_n(cpu_reset_n), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .bus(bus), .insn_done(insn_done));

// [tb_cbs_sequencer.sv]
`timescale 1ns/1ps
// ==========================================================
// Sequencer testbench
module tb_cbs_sequencer;
    logic mclk, rst, cpu_reset_n, irq_n, timer_req, irq_mask, cmd_valid, cmd_ready, insn_done, busy;
    cbs_pkg::cbs_cmd_t cmd;
    cbs_pkg::cbs_bus_t bus;
    logic [12:0] next_pc;
    logic [7:0] rdata;
    logic [15:0] vector;
    cbs_pkg::cbs_bus_t bus11;
    logic [7:0] rdata11;
    int err_total = 0;
    int n_checks = 0;
    int seed = 32'he36c;
    cbs_sequencer #(.PC11(1'b0), .EXT_BUS(1'b1), .POR_LEN(8)) i_cbs_sequencer (.mclk(mclk), .rst(rst),
        .cpu_reset_n(cpu_reset_n), .irq_n(irq_n), .timer_req(timer_req), .irq_mask(irq_mask), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .next_pc(next_pc), .rdata(rdata), .bus(bus),
        .insn_done(insn_done), .vector(vector), .busy(busy));
    cbs_mem i_cbs_mem (.bus(bus), .rdata(rdata));
    // Second part with the short program counter and the data bus kept on-chip.
    cbs_sequencer #(.PC11(1'b1), .EXT_BUS(1'b0), .POR_LEN(8)) i_cbs_sequencer_pc11 (.mclk(mclk), .rst(rst),
        .cpu_reset_n(cpu_reset_n), .irq_n(irq_n), .timer_req(timer_req), .irq_mask(irq_mask), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_ready(), .next_pc(next_pc), .rdata(rdata11), .bus(bus11), .insn_done(),
        .vector(), .busy());
    cbs_mem i_cbs_mem_pc11 (.bus(bus11), .rdata(rdata11));
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    function automatic logic [15:0] vec(input logic [12:0] hi, input logic [12:0] lo);
        return {(hi[7:0] ^ 8'h3C) & 8'h0F, (lo[7:0] ^ 8'h3C) & 8'h0F};
    endfunction
    // Packs length, write count and ignored-read count of one sequence.
    function automatic logic [15:0] prof(input cbs_pkg::cbs_cls_t c);
        case (c)
            cbs_pkg::CL_JMP16, cbs_pkg::CL_INH_RMW, cbs_pkg::CL_REL: return 16'h0100;
            cbs_pkg::CL_RD16: return 16'h0140;
            cbs_pkg::CL_ST16: return 16'h0188;
            cbs_pkg::CL_JSR16, cbs_pkg::CL_BIT: return {6'h0, 4'h7, 3'h2 >> (c == cbs_pkg::CL_BIT), 3'h0};
            cbs_pkg::CL_RTS: return 16'h0184;
            cbs_pkg::CL_SWI: return 16'h02E8;
            cbs_pkg::CL_RTI: return 16'h0247;
            cbs_pkg::CL_BRBIT: return 16'h0280;
            default: return 16'h0080;
        endcase
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic timeout();
        err_total++;
        print_verdict();
    endtask
    task automatic measure(output logic [15:0] got);
        logic [3:0] n;
        logic [2:0] w, g;
        n = 0;
        w = 0;
        g = 0;
        repeat (30)
        begin
            @(negedge mclk);
            if (insn_done === 1'b1 && n != 0)
            begin
                got = {6'h0, n, w, g};
                @(posedge mclk);
                return;
            end
            n++;
            w += 3'(bus.valid === 1'b1 && bus.rw === 1'b0);
            g += 3'(bus.ignore === 1'b1);
        end
        timeout();
    endtask
    task automatic issue(input cbs_pkg::cbs_cls_t c);
        cmd <= {c, 13'($random(seed)) & 13'h0FFF, 13'($random(seed)) & 13'h0FFF | 13'h0010, 32'($random(seed))};
        cmd_valid <= 1'b1;
        repeat (20)
        begin
            @(negedge mclk);
            if (cmd_ready === 1'b1)
            begin
                @(posedge mclk);
                return;
            end
        end
        timeout();
    endtask
    task automatic op(input cbs_pkg::cbs_cls_t c);
        logic [15:0] got;
        issue(c);
        cmd_valid <= 1'b0;
        measure(got);
        chk("profile", prof(c), got);
    endtask
    task automatic wait_idle();
        repeat (2000)
        begin
            @(negedge mclk);
            if (busy === 1'b0)
            begin
                @(posedge mclk);
                return;
            end
        end
        timeout();
    endtask
    task automatic take(input logic tmr);
        logic [15:0] got;
        next_pc <= 13'($random(seed)) & 13'h0FFF;
        if (tmr)
            timer_req <= 1'b1;
        else
            irq_n <= 1'b0;
        @(posedge mclk);
        timer_req <= 1'b0;
        irq_n <= 1'b1;
        measure(got);
        chk("irq profile", 16'h02A8, got);
        chk("irq vector", tmr ? vec(13'h1FF9, 13'h1FF8) : vec(13'h1FFA, 13'h1FFB), vector);
    endtask
    initial
    begin
        rst = 1'b1;
        cpu_reset_n = 1'b1;
        irq_n = 1'b1;
        timer_req = 1'b0;
        irq_mask = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        next_pc = 13'h0123;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        wait_idle();
        chk("por vector", vec(13'h1FFE, 13'h1FFF), vector);
        $display("test power-on done");
        for (int i = 0; i < 13; i++)
            op(cbs_pkg::cbs_cls_t'(i));
        repeat (30) op(cbs_pkg::cbs_cls_t'(4'($unsigned($random(seed)) % 13)));
        issue(cbs_pkg::CL_IMM);
        op(cbs_pkg::CL_IMM);
        $display("test sequences done");
        take(1'b0);
        take(1'b1);
        issue(cbs_pkg::CL_INH2);
        cmd_valid <= 1'b0;
        @(posedge mclk);
        take(1'b0);
        irq_mask <= 1'b1;
        irq_n <= 1'b0;
        repeat (4) @(negedge mclk);
        chk("masked busy", 16'h0, {15'h0, busy});
        @(posedge mclk) irq_n <= 1'b1;
        @(posedge mclk) irq_mask <= 1'b0;
        $display("test interrupts done");
        cpu_reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("page 07 hold", 16'h07FE, {3'h0, bus11.addr});
        cpu_reset_n <= 1'b1;
        wait_idle();
        chk("reset vector", vec(13'h1FFE, 13'h1FFF), vector);
        $display("test reset done");
        print_verdict();
    end
endmodule
